/* File: bench/net_master_model.sv */
// Far-side model: the master's view of the node and the rate store
`timescale 1ns/1ps
module net_master_model (
    input wire logic i_clock,                        // System clock
    input wire logic [2:0] i_mode,                   // Network scenario
    input wire logic i_nv_write,                     // Store request pulse
    input wire node_status_pkg::rate_t i_nv_rate,    // Rate to store
    output node_status_pkg::rate_t o_stored_rate,    // Stored rate
    output logic o_stored_ok,                        // Store holds a rate
    output node_status_pkg::net_state_t o_net        // Network state
);
    import node_status_pkg::*;

    // Store survives device resets and starts with the factory value
    initial begin
        o_stored_rate = FACTORY_RATE;
    end

    // Scenario 7 stands for a blank store
    assign o_stored_ok = (i_mode != 3'h7);

    // Take a new rate whenever the device asks for it
    always @(posedge i_clock) begin
        if (i_nv_write === 1'b1) begin
            o_stored_rate <= i_nv_rate;
        end
    end

    // One network state per scenario, as the master reports it
    always_comb begin
        case (i_mode)
            3'h1: o_net = 5'b11100;
            3'h2: o_net = 5'b10000;
            3'h3: o_net = 5'b10010;
            3'h4: o_net = 5'b10001;
            default: o_net = 5'b00000;
        endcase
    end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the node status indicator
`timescale 1ns/1ps
module tb;
    import node_status_pkg::*;
    localparam int SHOW = 50;
    localparam int SLOW = 8;
    localparam int FAST = 3;
    logic i_clock, i_rst_n, we, cyc, stb, o_wb_ack, o_wb_err, werr;
    logic nv_write, stored_ok, net_enable, meas_r, meas_g, bus_r, bus_g;
    logic [3:0] sw_tens, sw_units, adr, sel;
    logic [31:0] wdat, o_wb_dat, rdat;
    logic [2:0] mode;
    logic [5:0] node_addr;
    rate_t stored_rate, active_rate, nv_rate;
    net_state_t net;
    meas_state_t meas;
    int fail_count, comparisons, cycles, mr, mg, br, bg, both;

    fieldbus_node_status_indicator #(.RATE_SHOW(SHOW), .SLOW_HALF(SLOW),
        .FAST_HALF(FAST)) u_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sw_tens(sw_tens),
        .i_sw_units(sw_units), .i_stored_rate(stored_rate),
        .i_stored_ok(stored_ok), .i_net(net), .i_meas(meas),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
        .o_active_rate(active_rate), .o_node_addr(node_addr),
        .o_nv_write(nv_write), .o_nv_rate(nv_rate),
        .o_net_enable(net_enable), .o_meas_red(meas_r),
        .o_meas_green(meas_g), .o_bus_red(bus_r), .o_bus_green(bus_g));

    net_master_model u_master (
        .i_clock(i_clock), .i_mode(mode), .i_nv_write(nv_write),
        .i_nv_rate(nv_rate), .o_stored_rate(stored_rate),
        .o_stored_ok(stored_ok), .o_net(net));

    // Clock generator, 40 ns period
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // Hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            report_and_stop;
        end
    end

    task automatic chk_led(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: colour %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] part(input int c, input int n);
        return 32'(c > 0 && c < n);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // Count the cycles each light is on over a window
    task automatic watch(input int n);
        mr = 0; mg = 0; br = 0; bg = 0; both = 0;
        repeat (n) begin
            @(posedge i_clock);
            #1;
            mr += int'(meas_r); mg += int'(meas_g);
            br += int'(bus_r); bg += int'(bus_g);
            both += int'(meas_r & bus_r);
        end
    endtask

    task automatic restart;
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        tick(3);
    endtask

    // Classic single Wishbone cycle, held until ack or err
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= d; sel <= 4'hF;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1 && n < 20);
        rdat = o_wb_dat;
        werr = o_wb_err;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) chk_val(32'h0, 32'h1);
    endtask

    task automatic t_startup;
        mode <= 3'h4;
        restart;
        chk_val(32'(node_addr), 32'hC);
        chk_led(active_rate, RATE_125);
        chk_led({bus_r, bus_g}, LED_GREEN);
        tick(SHOW);
        chk_led({bus_r, bus_g}, LED_RED);
        mode <= 3'h0;
        tick(2);
        chk_led({bus_r, bus_g}, LED_OFF);
        chk_led({meas_r, meas_g}, LED_GREEN);
        $display("test startup done");
    endtask

    task automatic t_address;
        sw_tens <= 4'h6; sw_units <= 4'h4;
        restart;
        chk_val(32'(node_addr), 32'h3F);
        sw_tens <= 4'h0; sw_units <= 4'h0;
        restart;
        chk_val(32'(node_addr), 32'h0);
        sw_tens <= 4'h1; sw_units <= 4'h2;
        $display("test address done");
    endtask

    task automatic t_rate;
        rate_t r[3] = '{RATE_125, RATE_250, RATE_500};
        led_colour_t c[3] = '{LED_GREEN, LED_ORANGE, LED_RED};
        for (int i = 0; i < 3; i++) begin
            wb(REG_CONFIG, 1'b1, {30'h0, r[i]});
            tick(2);
            chk_led(active_rate, i == 0 ? RATE_125 : r[i - 1]);
            restart;
            chk_led(active_rate, r[i]);
            chk_led({bus_r, bus_g}, c[i]);
        end
        wb(REG_CONFIG, 1'b1, 32'h3);
        restart;
        chk_led(active_rate, RATE_500);
        mode <= 3'h7;
        restart;
        chk_led(active_rate, FACTORY_RATE);
        mode <= 3'h0;
        $display("test rate done");
    endtask

    task automatic t_meas;
        meas_state_t m[4] = '{4'hF, 4'h2, 4'h1, 4'h0};
        led_colour_t c[4] = '{LED_RED, LED_ORANGE, LED_ORANGE, LED_GREEN};
        for (int i = 0; i < 4; i++) begin
            meas <= m[i];
            tick(2);
            chk_led({meas_r, meas_g}, c[i]);
        end
        meas <= 4'h4;
        watch(2 * SLOW + 4);
        chk_val(part(mg, 2 * SLOW + 4), 32'h1);
        chk_val(32'(mr), 32'h0);
        meas <= 4'h0;
        $display("test measurement done");
    endtask

    task automatic t_bus;
        tick(SHOW);
        mode <= 3'h1;
        tick(2);
        chk_led({bus_r, bus_g}, LED_GREEN);
        chk_val(32'(net_enable), 32'h1);
        mode <= 3'h2;
        watch(2 * SLOW + 4);
        chk_val(part(bg, 2 * SLOW + 4) | 32'(br), 32'h1);
        mode <= 3'h3;
        watch(2 * SLOW + 4);
        chk_val(part(br, 2 * SLOW + 4) | 32'(bg), 32'h1);
        mode <= 3'h4;
        tick(2);
        chk_led({bus_r, bus_g}, LED_RED);
        chk_val(32'(net_enable), 32'h0);
        wb(REG_STATUS, 1'b0, 32'h0);
        chk_val(rdat & 32'h3F03, 32'h0C00);
        wb(4'hC, 1'b0, 32'h0);
        chk_val(32'(werr), 32'h1);
        $display("test bus done");
    endtask

    task automatic t_faults;
        mode <= 3'h1;
        wb(REG_CONTROL, 1'b1, 32'h1);
        tick(2);
        chk_val(32'(net_enable), 32'h0);
        watch(2 * FAST + 2);
        chk_val(32'(mr > 0 && br > 0 && both == 0), 32'h1);
        chk_val(32'(mg + bg), 32'h0);
        wb(REG_CONTROL, 1'b1, 32'h2);
        tick(2);
        watch(20);
        chk_val(32'(mr + br), 32'd40);
        restart;
        chk_led({meas_r, meas_g}, LED_GREEN);
        $display("test faults done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence; switch address 12 stays apart from the master's
    initial begin
        fail_count = 0; comparisons = 0; cycles = 0;
        i_rst_n = 1'b0; sw_tens = 4'h1; sw_units = 4'h2; mode = 3'h0;
        meas = 4'h0; adr = 4'h0; wdat = 32'h0; sel = 4'h0;
        we = 1'b0; cyc = 1'b0; stb = 1'b0;
        t_startup;
        t_address;
        t_rate;
        t_meas;
        t_bus;
        t_faults;
        report_and_stop;
    end
endmodule

/* File: core/address_decoder.sv */
// Converts two decimal switch digits into a node address
`timescale 1ns/1ps
module address_decoder (
    input wire logic [3:0] i_tens,   // Upper rotary switch
    input wire logic [3:0] i_units,  // Lower rotary switch
    output logic [6:0] o_addr,       // Combined address
    output logic o_valid             // Address is permitted
);
    import node_status_pkg::*;

    wire [6:0] tens_x10 = {i_tens, 3'h0} + {2'h0, i_tens, 1'h0};
    wire digits_ok = (i_tens <= 4'h9) && (i_units <= 4'h9);
    // Tens times ten plus units
    assign o_addr = tens_x10 + {3'h0, i_units};
    assign o_valid = digits_ok && (o_addr <= 7'(ADDR_MAX));
endmodule

/* File: core/blink_divider.sv */
// Clock divider with a square wave output
`timescale 1ns/1ps
module blink_divider #(
    parameter int HALF_CYCLES = 12500000
) (
    input wire logic i_clock,  // System clock
    input wire logic i_rst_n,  // Synchronous reset, active low
    output logic o_wave        // Square wave, half period HALF_CYCLES
);
    localparam int CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] count;
    wire wrap = (count == LAST);

    // Count cycles and flip the wave at each wrap
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count <= '0;
            o_wave <= 1'b0;
        end else if (wrap) begin
            count <= '0;
            o_wave <= ~o_wave;
        end else begin
            count <= count + CW'(1);
        end
    end
endmodule

/* File: core/fieldbus_node_status_indicator.sv */
// Node configuration and two tri-colour status indicators
`timescale 1ns/1ps
module fieldbus_node_status_indicator #(
    parameter int RATE_SHOW = node_status_pkg::RATE_SHOW_CYCLES,
    parameter int SLOW_HALF = node_status_pkg::SLOW_HALF_CYCLES,
    parameter int FAST_HALF = node_status_pkg::FAST_HALF_CYCLES
) (
    input wire logic i_clock,                         // 25 MHz clock
    input wire logic i_rst_n,                         // Power-on reset, low
    input wire logic [3:0] i_sw_tens,                 // Tens switch
    input wire logic [3:0] i_sw_units,                // Units switch
    input wire node_status_pkg::rate_t i_stored_rate, // Rate from storage
    input wire logic i_stored_ok,                     // Storage holds a rate
    input wire node_status_pkg::net_state_t i_net,    // Network state
    input wire node_status_pkg::meas_state_t i_meas,  // Measurement state
    input wire logic [3:0] i_wb_adr,                  // Wishbone address
    input wire logic [31:0] i_wb_dat,                 // Wishbone write data
    input wire logic [3:0] i_wb_sel,                  // Byte selects
    input wire logic i_wb_we,                         // Write enable
    input wire logic i_wb_cyc,                        // Cycle
    input wire logic i_wb_stb,                        // Strobe
    output logic [31:0] o_wb_dat,                     // Read data
    output logic o_wb_ack,                            // Acknowledge
    output logic o_wb_err,                            // Unmapped access
    output node_status_pkg::rate_t o_active_rate,     // Rate in use
    output logic [5:0] o_node_addr,                   // Node address in use
    output logic o_nv_write,                          // Store rate pulse
    output node_status_pkg::rate_t o_nv_rate,         // Rate to store
    output logic o_net_enable,                        // Network allowed
    output logic o_meas_red,                          // Upper LED red
    output logic o_meas_green,                        // Upper LED green
    output logic o_bus_red,                           // Lower LED red
    output logic o_bus_green                          // Lower LED green
);
    import node_status_pkg::*;

    localparam int SW = $clog2(RATE_SHOW + 1);

    logic [6:0] sw_addr;
    logic sw_valid;
    logic slow_wave;
    logic fast_wave;
    logic [SW-1:0] show_count;
    logic showing;
    logic started;
    logic fw_bad;
    logic int_err;
    logic rate_saved;
    logic ack;
    logic err;
    logic [31:0] rdata;
    led_pair_t leds;
    led_pair_t next_leds;

    address_decoder u_addr (
        .i_tens(i_sw_tens),
        .i_units(i_sw_units),
        .o_addr(sw_addr),
        .o_valid(sw_valid)
    );

    blink_divider #(.HALF_CYCLES(SLOW_HALF)) u_slow (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .o_wave(slow_wave)
    );

    blink_divider #(.HALF_CYCLES(FAST_HALF)) u_fast (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .o_wave(fast_wave)
    );

    // Bus decode
    wire req = i_wb_cyc && i_wb_stb && !ack && !err;
    wire hit_cfg = (i_wb_adr == REG_CONFIG);
    wire hit_st = (i_wb_adr == REG_STATUS);
    wire hit_ctl = (i_wb_adr == REG_CONTROL);
    wire mapped = hit_cfg || hit_st || hit_ctl;
    wire wr_cfg = req && i_wb_we && hit_cfg && i_wb_sel[0];
    wire wr_ctl = req && i_wb_we && hit_ctl && i_wb_sel[0];
    wire [1:0] wr_rate = i_wb_dat[CFG_RATE_LSB +: 2];
    wire rate_ok = (wr_rate == RATE_125) || (wr_rate == RATE_250)
        || (wr_rate == RATE_500);
    wire halted = fw_bad || int_err;
    wire show_end = (show_count == SW'(RATE_SHOW - 1));

    // Status word and read mux
    wire [31:0] status_word = {11'h000, rate_saved, fw_bad, halted,
        showing, sw_valid, 2'h0, o_node_addr, 6'h00, o_active_rate};
    wire [31:0] config_word = {18'h00000, o_node_addr, 6'h00, o_nv_rate};
    wire [31:0] control_word = {30'h00000000, int_err, fw_bad};
    assign rdata = hit_st ? status_word : hit_ctl ? control_word
        : config_word;

    // Wishbone answer one cycle after request
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
            err <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            ack <= req && mapped;
            err <= req && !mapped;
            o_wb_dat <= (req && mapped) ? rdata : 32'h00000000;
        end
    end
    assign o_wb_ack = ack;
    assign o_wb_err = err;

    // Rate and address latched once at start-up
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            started <= 1'b0;
            o_active_rate <= FACTORY_RATE;
            o_node_addr <= FACTORY_ADDR;
            o_nv_rate <= FACTORY_RATE;
        end else if (!started) begin
            started <= 1'b1;
            o_active_rate <= i_stored_ok ? i_stored_rate : FACTORY_RATE;
            o_nv_rate <= i_stored_ok ? i_stored_rate : FACTORY_RATE;
            o_node_addr <= sw_valid ? sw_addr[5:0] : FACTORY_ADDR;
        end else if (wr_cfg && rate_ok) begin
            o_nv_rate <= rate_t'(wr_rate);
        end
    end

    // Storage write pulse; active rate untouched until next start-up
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_nv_write <= 1'b0;
            rate_saved <= 1'b0;
        end else begin
            o_nv_write <= wr_cfg && rate_ok;
            if (wr_cfg && rate_ok) begin
                rate_saved <= 1'b1;
            end else if (wr_ctl && i_wb_dat[CTL_CLR_SAVED]) begin
                rate_saved <= 1'b0;
            end
        end
    end

    // Fault latches; only reset (power cycle) clears them
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            fw_bad <= 1'b0;
            int_err <= 1'b0;
        end else if (wr_ctl) begin
            fw_bad <= fw_bad | i_wb_dat[CTL_FW_BAD];
            int_err <= int_err | i_wb_dat[CTL_INT_ERR];
        end
    end

    // Start-up rate display timer
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            show_count <= '0;
            showing <= 1'b1;
        end else if (showing) begin
            show_count <= show_count + SW'(1);
            showing <= !show_end;
        end
    end

    assign o_net_enable = started && !halted && !i_net.critical_error;

    // Measurement indicator selection
    led_colour_t meas_norm;
    always_comb begin
        meas_norm = LED_GREEN;
        if (i_meas.error) begin
            meas_norm = LED_RED;
        end else if (i_meas.out_of_range || i_meas.limit_active) begin
            meas_norm = LED_ORANGE;
        end else if (i_meas.internal_ref) begin
            meas_norm = slow_wave ? LED_GREEN : LED_OFF;
        end
    end

    // Bus indicator selection
    led_colour_t bus_norm;
    led_colour_t rate_colour;
    always_comb begin
        unique case (o_active_rate)
            RATE_500: rate_colour = LED_RED;
            RATE_250: rate_colour = LED_ORANGE;
            default: rate_colour = LED_GREEN;
        endcase
        bus_norm = LED_OFF;
        if (!i_net.dup_check_done) begin
            bus_norm = LED_OFF;
        end else if (i_net.critical_error) begin
            bus_norm = LED_RED;
        end else if (i_net.conn_timeout) begin
            bus_norm = slow_wave ? LED_RED : LED_OFF;
        end else if (i_net.allocated && i_net.established) begin
            bus_norm = LED_GREEN;
        end else begin
            bus_norm = slow_wave ? LED_GREEN : LED_OFF;
        end
    end

    // Final priority: faults, then start-up display, then normal
    always_comb begin
        next_leds.meas = meas_norm;
        next_leds.bus = showing ? rate_colour : bus_norm;
        if (int_err) begin
            next_leds.meas = LED_RED;
            next_leds.bus = LED_RED;
        end else if (fw_bad) begin
            next_leds.meas = fast_wave ? LED_RED : LED_OFF;
            next_leds.bus = fast_wave ? LED_OFF : LED_RED;
        end
    end

    // Registered LED drivers
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            leds <= '{meas: LED_OFF, bus: LED_OFF};
        end else begin
            leds <= next_leds;
        end
    end
    assign o_meas_red = leds.meas[1];
    assign o_meas_green = leds.meas[0];
    assign o_bus_red = leds.bus[1];
    assign o_bus_green = leds.bus[0];

    chk_ack_one_cycle: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) o_wb_ack |=> !o_wb_ack)
        else $error("ack held more than one cycle");
    chk_rate_keeps: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) started && $past(started)
        |-> $stable(o_active_rate))
        else $error("active rate changed after start-up");
    chk_nv_pulse: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (wr_cfg && rate_ok) |=> o_nv_write)
        else $error("storage write missing");
    chk_addr_range: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (!started && sw_valid)
        |=> o_node_addr == $past(sw_addr))
        else $error("switch address not taken");
    chk_addr_factory: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (!started && !sw_valid)
        |=> o_node_addr == FACTORY_ADDR)
        else $error("bad switch setting not refused");
    chk_meas_red: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (i_meas.error && !fw_bad)
        |=> o_meas_red && !o_meas_green)
        else $error("measurement error not red");
    chk_bus_dark: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (!i_net.dup_check_done && !showing
        && !halted) |=> !o_bus_red && !o_bus_green)
        else $error("bus indicator lit before check");
    chk_critical_stop: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) i_net.critical_error |-> !o_net_enable)
        else $error("network still enabled on critical error");
    chk_internal_red: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) int_err |=> o_meas_red && o_bus_red
        && !o_meas_green && !o_bus_green)
        else $error("internal error not steady red");
    chk_fw_alternate: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (fw_bad && !int_err && $past(fw_bad))
        |=> o_meas_red != o_bus_red)
        else $error("firmware fault not alternating");
    chk_show_rate: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (showing && started && !halted
        && o_active_rate == RATE_500) |=> o_bus_red && !o_bus_green)
        else $error("start-up rate colour wrong");

    // Further checks on start-up, storage, indicator colours and network enable
    chk_rate_refused: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (wr_cfg && !rate_ok) |=> !o_nv_write)
        else $error("unsupported rate was stored");
    chk_factory_rate: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (!started && !i_stored_ok)
        |=> o_active_rate == FACTORY_RATE)
        else $error("blank store did not give factory rate");
    chk_meas_green: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (i_meas == '0 && !halted)
        |=> o_meas_green && !o_meas_red)
        else $error("measurement indicator not green");
    chk_meas_orange: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (!i_meas.error && !halted
        && (i_meas.out_of_range || i_meas.limit_active))
        |=> o_meas_green && o_meas_red)
        else $error("measurement indicator not orange");
    chk_bus_green: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (i_net.dup_check_done
        && !i_net.critical_error && !i_net.conn_timeout
        && i_net.allocated && i_net.established && !showing
        && !halted) |=> o_bus_green && !o_bus_red)
        else $error("bus indicator not steady green");
    chk_timeout_red: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) (i_net.dup_check_done
        && !i_net.critical_error && i_net.conn_timeout && !showing
        && !halted) |=> !o_bus_green)
        else $error("timeout shown in green");
    chk_halt_stop: assert property (@(posedge i_clock)
        disable iff (!i_rst_n) halted |-> !o_net_enable)
        else $error("network enabled while halted");

    cov_rate_saved: cover property (@(posedge i_clock) o_nv_write);
    cov_show_end: cover property (@(posedge i_clock) $fell(showing));
    cov_fw_bad: cover property (@(posedge i_clock) $rose(fw_bad));
    cov_unmapped: cover property (@(posedge i_clock) o_wb_err);
endmodule

/* File: include/node_status_pkg.sv */
// Package with constants and types for the node status indicator block
// Overview of operation
// - Node address is valid only when it lies between 0 and 63.
// - Address is tens switch times ten plus units switch; above 63 is refused.
// - Only bit rates 125, 250 and 500 kbit/s are supported.
// - New bit rate goes to storage at once; active rate changes at next start-up.
// - Factory stored setting is address 63 and 125 kbit/s.
// - For about one second after start-up the bus indicator shows the active rate.
// - Measurement indicator steady green when no error and values valid.
// - Measurement indicator flashes green while sampling internal references.
// - Measurement indicator orange on out-of-range or active limit switch.
// - Measurement indicator steady red on error, above all other measurement states.
// - Bus indicator dark until the duplicate node id check completes.
// - Bus indicator steady green when allocated and connections established.
// - Bus indicator flashes green while not allocated or not established.
// - Bus indicator flashes red on a recoverable connection timeout.
// - Bus indicator steady red on critical error; network traffic stops.
// - Corrupt firmware: both indicators flash red fast, alternating; no operation.
// - Internal error: both indicators steady red until power is cycled.
package node_status_pkg;

    // Indicator colour, two enables: bit1 red, bit0 green
    typedef enum logic [1:0] {
        LED_OFF = 2'h0,
        LED_GREEN = 2'h1,
        LED_RED = 2'h2,
        LED_ORANGE = 2'h3
    } led_colour_t;

    // Bit rate codes
    typedef enum logic [1:0] {
        RATE_125 = 2'h0,
        RATE_250 = 2'h1,
        RATE_500 = 2'h2
    } rate_t;

    // Network state reported by the protocol stack
    typedef struct packed {
        logic dup_check_done;
        logic allocated;
        logic established;
        logic conn_timeout;
        logic critical_error;
    } net_state_t;

    // Measurement state reported by the acquisition chain
    typedef struct packed {
        logic error;
        logic internal_ref;
        logic out_of_range;
        logic limit_active;
    } meas_state_t;

    // Pair of indicator colours
    typedef struct packed {
        led_colour_t meas;
        led_colour_t bus;
    } led_pair_t;

    localparam int CLOCK_HZ = 25000000;
    localparam int CLOCK_NS = 40;
    localparam int ADDR_MAX = 63;
    localparam int RATE_SHOW_MS = 1000;
    localparam int RATE_SHOW_CYCLES = RATE_SHOW_MS * (CLOCK_HZ / 1000);
    localparam int SLOW_HALF_MS = 500;
    localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * (CLOCK_HZ / 1000);
    localparam int FAST_HALF_MS = 100;
    localparam int FAST_HALF_CYCLES = FAST_HALF_MS * (CLOCK_HZ / 1000);
    localparam logic [5:0] FACTORY_ADDR = 6'h3F;
    localparam rate_t FACTORY_RATE = RATE_125;

    // Wishbone register byte addresses
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;

    // Field positions
    localparam int CFG_RATE_LSB = 0;
    localparam int CFG_ADDR_LSB = 8;
    localparam int ST_ACTIVE_RATE_LSB = 0;
    localparam int ST_NODE_ADDR_LSB = 8;
    localparam int ST_ADDR_VALID = 16;
    localparam int ST_SHOWING_RATE = 17;
    localparam int ST_HALTED = 18;
    localparam int ST_FW_BAD = 19;
    localparam int ST_RATE_SAVED = 20;
    localparam int CTL_FW_BAD = 0;
    localparam int CTL_INT_ERR = 1;
    localparam int CTL_CLR_SAVED = 2;

endpackage
